// ### frcb_consts.svh
// Offsets, bit positions, reset values and counts of the run control block
`ifndef FRCB_CONSTS_SVH
`define FRCB_CONSTS_SVH
`define FRCB_AW            12
`define FRCB_CLR_IDX       12'h312
`define FRCB_SET_IDX       12'h313
`define FRCB_MODE0_ADDR    12'h010
`define FRCB_SAP_ADDR      12'h014
`define FRCB_STATE_ADDR    12'h018
`define FRCB_ISTAT_ADDR    12'h020
`define FRCB_ICLR_ADDR     12'h024
`define FRCB_IEN_ADDR      12'h028
`define FRCB_BSEL_ADDR     12'h030
`define FRCB_BDATA_ADDR    12'h034
`define FRCB_B_START       0
`define FRCB_B_EOI         1
`define FRCB_B_SPECIAL     2
`define FRCB_B_GO_OFF      3
`define FRCB_B_DTIM        4
`define FRCB_B_SEARCH      5
`define FRCB_B_LEAVE       6
`define FRCB_B_PERIPH      0
`define FRCB_CTRL_RST      8'h00
`define FRCB_MODE0_RST     8'h00
`define FRCB_SAP_RST       32'h00000000
`define FRCB_LOCK_ADDR     7'h7F
`define FRCB_CLEAR_BYTE    8'h00
`define FRCB_I_GOOD        0
`define FRCB_I_BAD         1
`define FRCB_I_LEAVE       2
`define FRCB_NIRQ          3
`define FRCB_DBUF_BYTES    8
`endif

// ### frcb_pkg.sv
// Types shared by the run control block
package frcb_pkg;
   typedef enum logic [1:0] {
      FRCB_OFFLINE = 2'b00,
      FRCB_IDLE    = 2'b01,
      FRCB_SPECIAL = 2'b10
   } frcb_state_t;
   typedef enum logic [2:0] {
      FRCB_SD1 = 3'b000,
      FRCB_SD2 = 3'b001,
      FRCB_SD3 = 3'b010,
      FRCB_SD4 = 3'b011,
      FRCB_SC  = 3'b100
   } frcb_kind_t;
   typedef struct packed {
      logic       done;
      frcb_kind_t kind;
      logic       err;
      logic       special;
   } frcb_frame_t;
   typedef enum logic [1:0] {
      FRCB_LM_IDLE  = 2'b00,
      FRCB_LM_CLEAR = 2'b01,
      FRCB_LM_SWAP  = 2'b10,
      FRCB_LM_DONE  = 2'b11
   } frcb_lm_t;
endpackage : frcb_pkg

// ### frcb_irq.sv
// Sticky interrupt status, enable and level output
`timescale 1ns/1ps
`include "frcb_consts.svh"
module frcb_irq
   import frcb_pkg::*;
#(
   parameter int N = `FRCB_NIRQ
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [N-1:0] event_set,
   input  wire logic         clr_wr,
   input  wire logic         en_wr,
   input  wire logic [N-1:0] wdata,
   input  wire logic         interrupt_done_bit,
   output logic      [N-1:0] status,
   output logic      [N-1:0] enable,
   output logic              irq
);
   logic hold;
   // ------------------------------------------
   // Status and enable
   // ------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status <= (status & ~(clr_wr ? wdata : '0)) | event_set;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable <= '0;
      end else if (en_wr) begin
         enable <= wdata;
      end
   end
   // ------------------------------------------
   // Output, silenced after end of interrupt
   // ------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold <= 1'b0;
      end else if (|event_set) begin
         hold <= 1'b0;
      end else if (interrupt_done_bit) begin
         hold <= 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & enable) & ~hold & ~interrupt_done_bit;
      end
   end
endmodule : frcb_irq

// ### frcb_lm.sv
// Indication buffers and leave-master sequencer
`timescale 1ns/1ps
`include "frcb_consts.svh"
module frcb_lm
   import frcb_pkg::*;
#(
   parameter int DEPTH = `FRCB_DBUF_BYTES,
   parameter int IW    = $clog2(DEPTH)
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          start,
   input  wire logic          fill_valid,
   input  wire logic [IW-1:0] fill_idx,
   input  wire logic [7:0]    fill_data,
   output logic               fill_ready,
   input  wire logic [IW-1:0] rd_idx,
   output logic      [7:0]    rd_data,
   output logic               d_sel,
   output logic               done
);
   logic [7:0]    mem [2*DEPTH];
   frcb_lm_t      st;
   logic [IW-1:0] cnt;
   assign fill_ready = (st == FRCB_LM_IDLE);
   assign done       = (st == FRCB_LM_DONE);
   // ------------------------------------------
   // Sequence
   // ------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st  <= FRCB_LM_IDLE;
         cnt <= '0;
      end else begin
         case (st)
            FRCB_LM_IDLE: begin
               cnt <= '0;
               if (start) begin
                  st <= FRCB_LM_CLEAR;
               end
            end
            FRCB_LM_CLEAR: begin
               cnt <= cnt + 1'b1;
               if (cnt == IW'(DEPTH - 1)) begin
                  st <= FRCB_LM_SWAP;
               end
            end
            FRCB_LM_SWAP: st <= FRCB_LM_DONE;
            FRCB_LM_DONE: st <= FRCB_LM_IDLE;
            default:      st <= FRCB_LM_IDLE;
         endcase
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d_sel <= 1'b0;
      end else if (st == FRCB_LM_SWAP) begin
         d_sel <= ~d_sel;
      end
   end
   // ------------------------------------------
   // Buffer memory
   // ------------------------------------------
   always_ff @(posedge pclk) begin
      if (st == FRCB_LM_CLEAR) begin
         mem[{d_sel, cnt}] <= `FRCB_CLEAR_BYTE;
      end else if (fill_valid && fill_ready) begin
         mem[{~d_sel, fill_idx}] <= fill_data;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= mem[{d_sel, rd_idx}];
      end
   end
endmodule : frcb_lm

// ### frcb_top.sv
// Operating control register block with APB access
// Functional notes
// - The control bits have one set address and one clear address; a one marks a bit to change.
// - The start bit changes only while offline; interrupt done and special mode change any time.
// - Setting start leaves offline for passive idle, or special mode if that bit is set.
// - Leaving offline through start pulses the idle and sync timer start outputs.
// - Writing one to interrupt done silences the interrupt output and the bit drops back to zero.
// - In special mode only special frames are accepted.
// - Go-offline waits for the current job to finish and then enters offline.
// - Setting the delay timer bit stops the timer; clearing it through the clear address resets it.
// - In rate search an SD4 or complete good SD1/SD2/SD3 frame raises the good delimiter event; here a faulty SD4 raises the bad one instead.
// - In rate search a good short acknowledge raises no search event.
// - In rate search a faulty frame raises the bad delimiter event.
// - The leave-master bit acts only while the periphery mode bit is one.
// - Leave-master writes zero to every output byte of the data indication buffer.
// - After the clear, the data and next indication buffers are swapped.
// - Leave-master loads the lock value into the four requester address fields.
// - Leave-master then raises its event and drops the leave-master bit.
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "frcb_consts.svh"
module frcb_top
   import frcb_pkg::*;
#(
   parameter int DEPTH = `FRCB_DBUF_BYTES,
   parameter int IW    = $clog2(DEPTH)
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [`FRCB_AW-1:0]  paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire frcb_frame_t          frame,
   input  wire logic                 job_busy,
   input  wire logic                 fill_valid,
   input  wire logic [IW-1:0]        fill_idx,
   input  wire logic [7:0]           fill_data,
   output logic                      fill_ready,
   output logic                      frame_accept,
   output logic                      idle_timer_start,
   output logic                      sync_timer_start,
   output logic                      delay_timer_stop,
   output logic                      delay_timer_reset,
   output logic                      irq
);
   localparam logic [`FRCB_AW-1:0] SET_ADDR = `FRCB_AW'(`FRCB_SET_IDX << 2);
   localparam logic [`FRCB_AW-1:0] CLR_ADDR = `FRCB_AW'(`FRCB_CLR_IDX << 2);

   logic [7:0]              ctrl;
   logic [7:0]              next_ctrl;
   logic [7:0]              mode0;
   logic [31:0]             sap_req;
   logic [IW-1:0]           buf_sel;
   frcb_state_t             state;
   frcb_state_t             next_state;
   logic                    wr_en;
   logic                    wr_set;
   logic                    wr_clr;
   logic                    mapped;
   logic [7:0]              set_m;
   logic [7:0]              clr_m;
   logic                    periph;
   logic                    lm_start;
   logic                    lm_done;
   logic                    d_sel;
   logic [7:0]              buf_byte;
   logic                    ev_good;
   logic                    ev_bad;
   logic [`FRCB_NIRQ-1:0]   ev;
   logic [`FRCB_NIRQ-1:0]   istat;
   logic [`FRCB_NIRQ-1:0]   ien;
   logic [31:0]             rd_mux;
   logic                    go_offline_now;
   logic                    leave_offline_now;

   // ------------------------------------------
   // APB decode
   // ------------------------------------------
   assign wr_en  = psel && penable && pwrite;
   assign wr_set = wr_en && (paddr == SET_ADDR);
   assign wr_clr = wr_en && (paddr == CLR_ADDR);
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         SET_ADDR,
         CLR_ADDR,
         `FRCB_MODE0_ADDR,
         `FRCB_SAP_ADDR,
         `FRCB_STATE_ADDR,
         `FRCB_ISTAT_ADDR,
         `FRCB_ICLR_ADDR,
         `FRCB_IEN_ADDR,
         `FRCB_BSEL_ADDR,
         `FRCB_BDATA_ADDR: mapped = 1'b1;
         default:          mapped = 1'b0;
      endcase
   end
   assign pslverr = psel && penable && !mapped;

   // ------------------------------------------
   // Set and clear masks
   // ------------------------------------------
   assign periph = mode0[`FRCB_B_PERIPH];
   always_comb begin
      set_m = wr_set ? pwdata[7:0] : 8'h00;
      clr_m = wr_clr ? pwdata[7:0] : 8'h00;
      if (state != FRCB_OFFLINE) begin
         set_m[`FRCB_B_START] = 1'b0;
         clr_m[`FRCB_B_START] = 1'b0;
      end
      if (!periph || ctrl[`FRCB_B_LEAVE]) begin
         set_m[`FRCB_B_LEAVE] = 1'b0;
      end
      clr_m[`FRCB_B_EOI] = 1'b0;
      set_m[7] = 1'b0;
      clr_m[7] = 1'b0;
   end
   assign lm_start = set_m[`FRCB_B_LEAVE];

   // ------------------------------------------
   // Control bits
   // ------------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      if (ctrl[`FRCB_B_EOI]) begin
         next_ctrl[`FRCB_B_EOI] = 1'b0;
      end
      if (go_offline_now) begin
         next_ctrl[`FRCB_B_START]  = 1'b0;
         next_ctrl[`FRCB_B_GO_OFF] = 1'b0;
      end
      if (lm_done) begin
         next_ctrl[`FRCB_B_LEAVE] = 1'b0;
      end
      next_ctrl = (next_ctrl & ~clr_m) | set_m;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `FRCB_CTRL_RST;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ------------------------------------------
   // Operating state
   // ------------------------------------------
   assign leave_offline_now = (state == FRCB_OFFLINE) && ctrl[`FRCB_B_START];
   assign go_offline_now    = (state != FRCB_OFFLINE) && ctrl[`FRCB_B_GO_OFF]
                              && !job_busy;
   always_comb begin
      next_state = state;
      case (state)
         FRCB_OFFLINE: begin
            if (ctrl[`FRCB_B_START]) begin
               next_state = ctrl[`FRCB_B_SPECIAL] ? FRCB_SPECIAL : FRCB_IDLE;
            end
         end
         FRCB_IDLE: begin
            if (go_offline_now) begin
               next_state = FRCB_OFFLINE;
            end else if (ctrl[`FRCB_B_SPECIAL]) begin
               next_state = FRCB_SPECIAL;
            end
         end
         FRCB_SPECIAL: begin
            if (go_offline_now) begin
               next_state = FRCB_OFFLINE;
            end else if (!ctrl[`FRCB_B_SPECIAL]) begin
               next_state = FRCB_IDLE;
            end
         end
         default: next_state = FRCB_OFFLINE;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= FRCB_OFFLINE;
      end else begin
         state <= next_state;
      end
   end

   // ------------------------------------------
   // Timers
   // ------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_timer_start <= 1'b0;
         sync_timer_start <= 1'b0;
      end else begin
         idle_timer_start <= leave_offline_now;
         sync_timer_start <= leave_offline_now;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         delay_timer_stop  <= 1'b0;
         delay_timer_reset <= 1'b0;
      end else begin
         delay_timer_stop  <= next_ctrl[`FRCB_B_DTIM];
         delay_timer_reset <= clr_m[`FRCB_B_DTIM];
      end
   end

   // ------------------------------------------
   // Frame filter and rate search
   // ------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_accept <= 1'b0;
      end else begin
         frame_accept <= frame.done && (state != FRCB_OFFLINE)
                         && ((state != FRCB_SPECIAL) || frame.special);
      end
   end
   always_comb begin
      ev_good = 1'b0;
      ev_bad  = 1'b0;
      if (frame.done && ctrl[`FRCB_B_SEARCH]) begin
         if (frame.err) begin
            ev_bad = 1'b1;
         end else begin
            case (frame.kind)
               FRCB_SD1,
               FRCB_SD2,
               FRCB_SD3,
               FRCB_SD4: ev_good = 1'b1;
               FRCB_SC:  ev_good = 1'b0;
               default:  ev_good = 1'b0;
            endcase
         end
      end
   end
   always_comb begin
      ev                = '0;
      ev[`FRCB_I_GOOD]  = ev_good;
      ev[`FRCB_I_BAD]   = ev_bad;
      ev[`FRCB_I_LEAVE] = lm_done;
   end

   // ------------------------------------------
   // Mode and requester address registers
   // ------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode0 <= `FRCB_MODE0_RST;
      end else if (wr_en && (paddr == `FRCB_MODE0_ADDR)) begin
         mode0 <= pwdata[7:0];
      end
   end
   generate
      for (genvar i = 0; i < 4; i++) begin : g_sap
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sap_req[8*i +: 8] <= 8'(`FRCB_SAP_RST >> (8*i));
            end else if (lm_done) begin
               sap_req[8*i +: 8] <= {1'b0, `FRCB_LOCK_ADDR};
            end else if (wr_en && (paddr == `FRCB_SAP_ADDR)) begin
               sap_req[8*i +: 8] <= {1'b0, pwdata[8*i +: 7]};
            end
         end
      end
   endgenerate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_sel <= '0;
      end else if (wr_en && (paddr == `FRCB_BSEL_ADDR)) begin
         buf_sel <= pwdata[IW-1:0];
      end
   end

   // ------------------------------------------
   // Read data
   // ------------------------------------------
   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         SET_ADDR,
         CLR_ADDR:           rd_mux[7:0] = ctrl;
         `FRCB_MODE0_ADDR:   rd_mux[7:0] = mode0;
         `FRCB_SAP_ADDR:     rd_mux = sap_req;
         `FRCB_STATE_ADDR:   rd_mux[3:0] = {1'b0, d_sel, state};
         `FRCB_ISTAT_ADDR:   rd_mux[`FRCB_NIRQ-1:0] = istat;
         `FRCB_IEN_ADDR:     rd_mux[`FRCB_NIRQ-1:0] = ien;
         `FRCB_BSEL_ADDR:    rd_mux[IW-1:0] = buf_sel;
         `FRCB_BDATA_ADDR:   rd_mux[7:0] = buf_byte;
         default:            rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // ------------------------------------------
   // Leave-master sequencer and interrupts
   // ------------------------------------------
   frcb_lm #(
      .DEPTH (DEPTH),
      .IW    (IW)
   ) u_lm (
      .pclk       (pclk),
      .presetn    (presetn),
      .start      (lm_start),
      .fill_valid (fill_valid),
      .fill_idx   (fill_idx),
      .fill_data  (fill_data),
      .fill_ready (fill_ready),
      .rd_idx     (buf_sel),
      .rd_data    (buf_byte),
      .d_sel      (d_sel),
      .done       (lm_done)
   );
   frcb_irq #(
      .N (`FRCB_NIRQ)
   ) u_irq (
      .pclk      (pclk),
      .presetn   (presetn),
      .event_set (ev),
      .clr_wr    (wr_en && (paddr == `FRCB_ICLR_ADDR)),
      .en_wr     (wr_en && (paddr == `FRCB_IEN_ADDR)),
      .wdata     (pwdata[`FRCB_NIRQ-1:0]),
      .interrupt_done_bit       (set_m[`FRCB_B_EOI]),
      .status    (istat),
      .enable    (ien),
      .irq       (irq)
   );
endmodule : frcb_top

// ### frcb_top_asserts.sv
// Checker for the run control block ports
`timescale 1ns/1ps
`include "frcb_consts.svh"
module frcb_top_asserts
   import frcb_pkg::*;
#(
   parameter int DEPTH = `FRCB_DBUF_BYTES,
   parameter int IW    = $clog2(DEPTH)
) (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [`FRCB_AW-1:0] paddr,
   input wire logic [31:0]         pwdata,
   input wire logic                pslverr,
   input wire frcb_frame_t         frame,
   input wire logic                fill_ready,
   input wire logic                frame_accept,
   input wire logic                idle_timer_start,
   input wire logic                sync_timer_start,
   input wire logic                delay_timer_stop,
   input wire logic                delay_timer_reset,
   input wire logic                irq
);
   localparam logic [11:0] SET_A  = `FRCB_SET_IDX << 2;
   localparam logic [11:0] CLR_A  = `FRCB_CLR_IDX << 2;
   localparam int          LM_MAX = DEPTH + 4;
   logic wr_set;
   logic wr_clr;
   assign wr_set = psel && penable && pwrite && (paddr == SET_A);
   assign wr_clr = psel && penable && pwrite && (paddr == CLR_A);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----
   // Assertions
   // ----
   a_addr_mapped: assert property (psel && penable && (paddr == SET_A || paddr == CLR_A)
      |-> !pslverr) else $error("control address refused");
   a_eoi_quiet: assert property (wr_set && pwdata[1] |=> !irq)
      else $error("irq not silenced");
   a_dtim_stop: assert property (wr_set && pwdata[4] |=> delay_timer_stop)
      else $error("delay timer not stopped");
   a_dtim_reset: assert property (delay_timer_reset == $past(wr_clr && pwdata[4]))
      else $error("delay timer reset pulse wrong");
   a_timers_pair: assert property (idle_timer_start |-> sync_timer_start ##1 !idle_timer_start)
      else $error("timer start pulses wrong");
   a_start_cause: assert property (idle_timer_start |-> $past(wr_set && pwdata[0], 2))
      else $error("timer start without start write");
   a_accept_cause: assert property (frame_accept |-> $past(frame.done))
      else $error("accept without frame");
   a_lm_cause: assert property ($fell(fill_ready) |-> $past(wr_set && pwdata[6]))
      else $error("leave sequence without command");
   a_lm_bounded: assert property ($fell(fill_ready) |-> ##[1:LM_MAX] fill_ready)
      else $error("leave sequence too long");
   c_leave: cover property (wr_set && pwdata[6]);
   c_start: cover property (idle_timer_start);
   c_accept: cover property (frame_accept);
   c_dreset: cover property (delay_timer_reset);
endmodule : frcb_top_asserts

bind frcb_top frcb_top_asserts #(.DEPTH(DEPTH), .IW(IW)) u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .frame(frame),
   .fill_ready(fill_ready), .frame_accept(frame_accept),
   .idle_timer_start(idle_timer_start), .sync_timer_start(sync_timer_start),
   .delay_timer_stop(delay_timer_stop), .delay_timer_reset(delay_timer_reset), .irq(irq)
);

// ### frcb_host.sv
// APB host model issuing control register transfers
`timescale 1ns/1ps
module frcb_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
   end
   // One transfer; ones mark the bits to set or clear at the chosen address
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
endmodule : frcb_host

// ### frcb_top_tb.sv
// Testbench for the run control block
`timescale 1ns/1ps
`include "frcb_consts.svh"
module frcb_top_tb
   import frcb_pkg::*;
;
   localparam logic [11:0] SET_A = `FRCB_SET_IDX << 2;
   localparam logic [11:0] CLR_A = `FRCB_CLR_IDX << 2;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rq;
   frcb_frame_t frame;
   logic        job_busy, fill_valid, fill_ready, frame_accept, irq;
   logic        idle_timer_start, sync_timer_start, delay_timer_stop, delay_timer_reset;
   logic [2:0]  fill_idx;
   logic [7:0]  fill_data;
   int          n_errors = 0, n_compared = 0, n_idle = 0, n_sync = 0, n_dres = 0, n_acc = 0;
   frcb_top #(.DEPTH(8)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame(frame), .job_busy(job_busy), .fill_valid(fill_valid), .fill_idx(fill_idx),
      .fill_data(fill_data), .fill_ready(fill_ready), .frame_accept(frame_accept),
      .idle_timer_start(idle_timer_start), .sync_timer_start(sync_timer_start),
      .delay_timer_stop(delay_timer_stop), .delay_timer_reset(delay_timer_reset), .irq(irq));
   frcb_host host (
      .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      n_idle += (idle_timer_start === 1'b1);
      n_sync += (sync_timer_start === 1'b1);
      n_dres += (delay_timer_reset === 1'b1);
      n_acc += (frame_accept === 1'b1);
   end
   // ----
   // Tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rq, re);
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      host.xfer(1'b0, a, 32'h0, rq, re);
      chk(rq, exp);
   endtask : rdc
   task automatic send(input frcb_kind_t k, input logic er, input logic sp);
      @(posedge pclk);
      frame <= '{done: 1'b1, kind: k, err: er, special: sp};
      @(posedge pclk);
      frame <= '0;
      repeat (2) @(posedge pclk);
   endtask : send
   task automatic lm_wait;
      @(negedge pclk);
      chk(fill_ready, 32'h0);
      for (int w = 0; w < 40 && fill_ready !== 1'b1; w++) @(posedge pclk);
      chk(fill_ready, 32'h1);
   endtask : lm_wait
   task automatic bufchk(input logic [7:0] b, input logic inc);
      for (int i = 0; i < 8; i++) begin
         wr(`FRCB_BSEL_ADDR, i);
         repeat (2) @(posedge pclk);
         rdc(`FRCB_BDATA_ADDR, b + (inc ? i : 0));
      end
   endtask : bufchk
   task automatic close_out;
      $display("Mismatches %0d, compares %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   // ----
   // Sequence
   // ----
   initial begin
      #100000;
      n_errors++;
      close_out();
   end
   initial begin
      presetn = 1'b0;
      frame = '0;
      job_busy = 1'b0;
      fill_valid = 1'b0;
      fill_idx = 3'h0;
      fill_data = 8'h00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc(SET_A, 32'h0);
      rdc(`FRCB_STATE_ADDR, 32'h0);
      host.xfer(1'b0, 12'h100, 32'h0, rq, re);
      chk({31'h0, re}, 32'h1);
      wr(SET_A, 32'h10);
      @(negedge pclk);
      chk(delay_timer_stop, 32'h1);
      wr(SET_A, 32'h0);
      wr(CLR_A, 32'h0);
      rdc(SET_A, 32'h10);
      wr(CLR_A, 32'h10);
      rdc(CLR_A, 32'h0);
      chk(n_dres, 32'h1);
      wr(SET_A, 32'h20);
      for (int k = 0; k < 4; k++) begin
         send(frcb_kind_t'(k), 1'b0, 1'b0);
         rdc(`FRCB_ISTAT_ADDR, 32'h1);
         wr(`FRCB_ICLR_ADDR, 32'h1);
      end
      send(FRCB_SC, 1'b0, 1'b0);
      rdc(`FRCB_ISTAT_ADDR, 32'h0);
      send(FRCB_SD2, 1'b1, 1'b0);
      rdc(`FRCB_ISTAT_ADDR, 32'h2);
      chk(irq, 32'h0);
      wr(`FRCB_IEN_ADDR, 32'h7);
      rdc(`FRCB_IEN_ADDR, 32'h7);
      chk(irq, 32'h1);
      wr(SET_A, 32'h02);
      @(negedge pclk);
      chk(irq, 32'h0);
      rdc(SET_A, 32'h20);
      wr(`FRCB_ICLR_ADDR, 32'h7);
      wr(CLR_A, 32'h20);
      chk(n_acc, 32'h0);
      wr(SET_A, 32'h05);
      rdc(`FRCB_STATE_ADDR, 32'h2);
      chk(n_idle, 32'h1);
      chk(n_sync, 32'h1);
      send(FRCB_SD2, 1'b0, 1'b0);
      send(FRCB_SD2, 1'b0, 1'b1);
      chk(n_acc, 32'h1);
      wr(CLR_A, 32'h05);
      rdc(`FRCB_STATE_ADDR, 32'h1);
      rdc(SET_A, 32'h01);
      @(posedge pclk);
      job_busy <= 1'b1;
      wr(SET_A, 32'h08);
      repeat (3) @(posedge pclk);
      rdc(`FRCB_STATE_ADDR, 32'h1);
      @(posedge pclk);
      job_busy <= 1'b0;
      rdc(`FRCB_STATE_ADDR, 32'h0);
      rdc(SET_A, 32'h0);
      wr(SET_A, 32'h40);
      rdc(SET_A, 32'h0);
      for (int i = 0; i < 8; i++) begin
         @(posedge pclk);
         fill_valid <= 1'b1;
         fill_idx <= 3'(i);
         fill_data <= 8'(8'hA0 + i);
      end
      @(posedge pclk);
      fill_valid <= 1'b0;
      wr(`FRCB_MODE0_ADDR, 32'h1);
      wr(SET_A, 32'h40);
      lm_wait();
      rdc(`FRCB_SAP_ADDR, 32'h7F7F7F7F);
      rdc(SET_A, 32'h0);
      rdc(`FRCB_ISTAT_ADDR, 32'h4);
      rdc(`FRCB_STATE_ADDR, 32'h4);
      bufchk(8'hA0, 1'b1);
      wr(SET_A, 32'h40);
      lm_wait();
      rdc(`FRCB_STATE_ADDR, 32'h0);
      bufchk(`FRCB_CLEAR_BYTE, 1'b0);
      close_out();
   end
endmodule : frcb_top_tb
